// file: hdl/hss_sequencer.sv
// Hot-swap sequencer: start delay, filtered and fast shutdowns, power-good.
//
// Operation
// - Enable low for 10 ms switches off.
// - Latched trip cleared by 10 ms enable low.
// - Wait 150 ms before starting gate ramp.
// - Same delay used for automatic restart.
// - Trip or overtemperature turns off unfiltered.
// - Undervoltage must last 10 ms to shut down.
// - Over 125 degrees turns the switch off.
// - Thermal fault restarts below 110 degrees.
// - Breaker builds: good needs enhancement, low drop.
// - No-breaker build: good needs enhancement only.
// - Good drops fast on trip or overheat.
// - Good drops after 10 ms lockout or enable.
// - Build option picks power-good polarity.
// - Drop compared only while fully enhanced.
// - No-breaker build never trips on drop.
// - Retry restarts after 150 ms clean conditions.
// - Power cycle also clears latched trip.
`timescale 1ns/10ps
`default_nettype none
module hss_sequencer
   import hss_pkg::*;
#(
   parameter hss_policy_e POLICY         = HSS_POL_LATCHED,
   parameter bit          GOOD_ACTIVE_LO = 1'b1,
   parameter int          OFF_FILT_CYC   = OFF_FILTER_CYC,
   parameter int          START_CYC      = START_DELAY_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Pins and analog comparators, all asynchronous.
   input  wire logic        enable_pin,
   input  wire logic        undervolt_pin,
   input  wire logic        temp_hot_pin,
   input  wire logic        temp_cool_pin,
   input  wire logic        full_enh_pin,
   input  wire logic        drop_over_pin,
   // Gate ramp request to the analog driver.
   output logic             gate_on,
   // Open-drain power-good pin.
   input  wire logic        power_ok_in,
   output logic             power_ok_out,
   output logic             power_ok_oe_b
);

   // ------------------------------------------------------------
   // Input synchronisers and filters
   // ------------------------------------------------------------
   localparam int NSYNC = 7;
   localparam int SC_W  = $clog2(START_CYC + 1);
   localparam logic [SC_W-1:0] START_TERM = SC_W'(START_CYC - 1);
   localparam bit BREAKER_EN = (POLICY != HSS_POL_NONE);

   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] pins_s;
   logic             en_s;
   logic             uv_s;
   logic             hot_s;
   logic             cool_s;
   logic             enh_s;
   logic             drop_s;
   logic             pin_s;
   logic             en_low_filt;
   logic             uv_filt;

   assign pins_raw = {power_ok_in, drop_over_pin, full_enh_pin, temp_cool_pin,
                      temp_hot_pin, undervolt_pin, enable_pin};

   // Every comparator and pin passes two flops before use.
   hss_sync #(
      .W (NSYNC)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d       (pins_raw),
      .q       (pins_s)
   );

   assign en_s   = pins_s[0];
   assign uv_s   = pins_s[1];
   assign hot_s  = pins_s[2];
   assign cool_s = pins_s[3];
   assign enh_s  = pins_s[4];
   assign drop_s = pins_s[5];
   assign pin_s  = pins_s[6];

   // Enable low must persist before it counts.
   hss_persist #(
      .CYCLES (OFF_FILT_CYC)
   ) u_en_filt (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .lvl     (!en_s),
      .held    (en_low_filt)
   );

   // Undervoltage must persist before it counts.
   hss_persist #(
      .CYCLES (OFF_FILT_CYC)
   ) u_uv_filt (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .lvl     (uv_s),
      .held    (uv_filt)
   );

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic        ack_reg;
   logic        swen_reg;
   logic [31:0] rdata_next;
   logic [31:0] stat_word;
   hss_state_e  state_reg;
   hss_state_e  state_next;
   logic        latch_reg;
   logic        therm_reg;
   logic        good_reg;

   // One wait state per access keeps read data registered.
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
      end
   end

   // Software enable acts as an extra hold-off beside the pin.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         swen_reg <= CTRL_SWEN_RST;
      end else if (avs_write && ack_reg && avs_address == CTRL_OFS && avs_byteenable[0]) begin
         swen_reg <= avs_writedata[CTRL_SWEN_BIT];
      end
   end

   // Status word mirrors the live state of the block.
   always_comb begin
      stat_word = '0;
      stat_word[STAT_STATE_LSB +: 2] = state_reg;
      stat_word[STAT_GATE_BIT]       = gate_on;
      stat_word[STAT_GOOD_BIT]       = good_reg;
      stat_word[STAT_LATCH_BIT]      = latch_reg;
      stat_word[STAT_THERM_BIT]      = therm_reg;
      stat_word[STAT_UV_BIT]         = uv_filt;
      stat_word[STAT_ENLOW_BIT]      = en_low_filt;
      stat_word[STAT_PIN_BIT]        = pin_s;
   end

   // Unmapped addresses read as zero and ignore writes.
   always_comb begin
      unique case (avs_address)
         CTRL_OFS: rdata_next = {31'h0000_0000, swen_reg};
         STAT_OFS: rdata_next = stat_word;
         default:  rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // Fault tracking
   // ------------------------------------------------------------
   logic en_low_d_reg;
   logic en_release;
   logic trip;
   logic start_ok;
   logic on_now;

   assign on_now = (state_reg == HSS_ST_RAMP) || (state_reg == HSS_ST_ON);

   // Breaker looks at the drop only once the switch is fully enhanced.
   assign trip = BREAKER_EN && on_now && enh_s && drop_s;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         en_low_d_reg <= 1'b0;
      end else begin
         en_low_d_reg <= en_low_filt;
      end
   end

   // A filtered low followed by release re-arms a latched breaker.
   assign en_release = en_low_d_reg && !en_low_filt;

   // Reset on power-up clears the latch; a new trip beats a clear.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch_reg <= 1'b0;
      end else if (trip && POLICY == HSS_POL_LATCHED) begin
         latch_reg <= 1'b1;
      end else if (en_release) begin
         latch_reg <= 1'b0;
      end
   end

   // Thermal shutdown with hysteresis between the two comparators.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         therm_reg <= 1'b0;
      end else if (hot_s) begin
         therm_reg <= 1'b1;
      end else if (cool_s) begin
         therm_reg <= 1'b0;
      end
   end

   // Start conditions; hot_s is included so the set cycle already blocks.
   assign start_ok = !uv_filt && !en_low_filt && !therm_reg && !hot_s
                     && swen_reg && !latch_reg;

   // ------------------------------------------------------------
   // Start delay counter
   // ------------------------------------------------------------
   logic [SC_W-1:0] start_cnt_reg;
   logic            start_done;

   assign start_done = (start_cnt_reg == START_TERM);

   // Counts only in the start state; any break restarts the full delay.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         start_cnt_reg <= '0;
      end else if (state_reg != HSS_ST_START || !start_ok) begin
         start_cnt_reg <= '0;
      end else if (!start_done) begin
         start_cnt_reg <= start_cnt_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Sequencer state machine
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         HSS_ST_OFF: begin
            if (start_ok) begin
               state_next = HSS_ST_START;
            end
         end
         HSS_ST_START: begin
            // Power-up, release and retry all share this one delay.
            if (!start_ok) begin
               state_next = HSS_ST_OFF;
            end else if (start_done) begin
               state_next = HSS_ST_RAMP;
            end
         end
         HSS_ST_RAMP, HSS_ST_ON: begin
            if (trip || hot_s) begin
               state_next = HSS_ST_OFF;
            end else if (uv_filt || en_low_filt || !swen_reg) begin
               state_next = HSS_ST_OFF;
            end else if (enh_s) begin
               state_next = HSS_ST_ON;
            end else begin
               state_next = HSS_ST_RAMP;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= HSS_ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Gate follows the next state so shutdown costs one edge only.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gate_on <= 1'b0;
      end else begin
         gate_on <= (state_next == HSS_ST_RAMP) || (state_next == HSS_ST_ON);
      end
   end

   // ------------------------------------------------------------
   // Power-good
   // ------------------------------------------------------------
   // The ON state already requires enhancement and, with a breaker,
   // a drop below threshold, since a high drop trips out of it.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         good_reg <= 1'b0;
      end else begin
         good_reg <= (state_next == HSS_ST_ON);
      end
   end

   // Open-drain pin: the output level is always low; the enable decides.
   // Active-low builds pull down when good; active-high builds when not.
   assign power_ok_out  = 1'b0;
   assign power_ok_oe_b = GOOD_ACTIVE_LO ? !good_reg : good_reg;

endmodule
`default_nettype wire

// file: hdl/hss_pkg.sv
// Shared constants and types of the hot-swap sequencer.
package hss_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 40_000_000;
   localparam int OFF_FILTER_MS   = 10;
   localparam int START_DELAY_MS  = 150;
   localparam int FAST_OFF_US     = 4;
   // Least times round up; these divide exactly at 40 MHz.
   localparam int OFF_FILTER_CYC  = OFF_FILTER_MS * (CLK_HZ / 1000);
   localparam int START_DELAY_CYC = START_DELAY_MS * (CLK_HZ / 1000);
   // Longest time, rounded down; the turn-off path is far shorter.
   localparam int FAST_OFF_CYC    = FAST_OFF_US * (CLK_HZ / 1_000_000);

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0]  CTRL_OFS      = 4'h0;
   localparam logic [3:0]  STAT_OFS      = 4'h4;
   localparam int          CTRL_SWEN_BIT = 0;
   localparam logic        CTRL_SWEN_RST = 1'b1;
   localparam int          STAT_STATE_LSB   = 0;
   localparam int          STAT_GATE_BIT    = 2;
   localparam int          STAT_GOOD_BIT    = 3;
   localparam int          STAT_LATCH_BIT   = 4;
   localparam int          STAT_THERM_BIT   = 5;
   localparam int          STAT_UV_BIT      = 6;
   localparam int          STAT_ENLOW_BIT   = 7;
   localparam int          STAT_PIN_BIT     = 8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      HSS_POL_LATCHED = 2'h0,
      HSS_POL_RETRY   = 2'h1,
      HSS_POL_NONE    = 2'h2
   } hss_policy_e;

   typedef enum logic [1:0] {
      HSS_ST_OFF   = 2'h0,
      HSS_ST_START = 2'h1,
      HSS_ST_RAMP  = 2'h3,
      HSS_ST_ON    = 2'h2
   } hss_state_e;

endpackage

// file: hdl/hss_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module hss_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------
   logic [W-1:0] meta_reg;

   // The first stage feeds only the second, so a metastable value never spreads.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule
`default_nettype wire

// file: hdl/hss_persist.sv
// Persistence filter: flags a level that has held for a set number of cycles.
`timescale 1ns/10ps
`default_nettype none
module hss_persist #(
   parameter int CYCLES = 400_000
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic lvl,
   output logic      held
);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] TERM = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;

   // Any drop of the level restarts the count, so short pulses are ignored.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else if (!lvl) begin
         cnt_reg <= '0;
      end else if (cnt_reg != TERM) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // Flag rises the cycle after the level has been seen CYCLES times.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         held <= 1'b0;
      end else begin
         held <= lvl && (cnt_reg == TERM);
      end
   end

endmodule
`default_nettype wire

// file: bench/hss_sequencer_props.sv
// Port-level assertions for the hot-swap sequencer.
`timescale 1ns/10ps
`default_nettype none
module hss_sequencer_chk
   import hss_pkg::*;
#(
   parameter hss_policy_e POLICY         = HSS_POL_LATCHED,
   parameter bit          GOOD_ACTIVE_LO = 1'b1,
   parameter int          OFF_FILT_CYC   = OFF_FILTER_CYC,
   parameter int          START_CYC      = START_DELAY_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic enable_pin,
   input wire logic undervolt_pin,
   input wire logic temp_hot_pin,
   input wire logic full_enh_pin,
   input wire logic drop_over_pin,
   input wire logic gate_on,
   input wire logic power_ok_out,
   input wire logic power_ok_oe_b
);
   // ------
   // Helper logic
   // ------
   logic good;
   logic brk;
   int   off_cnt;
   int   en_cnt;
   int   uv_cnt;
   assign good = GOOD_ACTIVE_LO ? !power_ok_oe_b : power_ok_oe_b;
   assign brk  = (POLICY != HSS_POL_NONE);

   // Run lengths saturate, so a long idle never wraps into a false match.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         off_cnt <= 0;
         en_cnt  <= 0;
         uv_cnt  <= 0;
      end else begin
         off_cnt <= gate_on ? 0 : (off_cnt < START_CYC ? off_cnt + 1 : off_cnt);
         en_cnt  <= enable_pin ? 0 : (en_cnt < OFF_FILT_CYC + 8 ? en_cnt + 1 : en_cnt);
         uv_cnt  <= !undervolt_pin ? 0 : (uv_cnt < OFF_FILT_CYC + 8 ? uv_cnt + 1 : uv_cnt);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // ------
   // Properties
   // ------
   property p_hot;   temp_hot_pin [*4] |-> !gate_on && !good; endproperty
   property p_trip;  (brk && full_enh_pin && drop_over_pin) [*4] |-> !gate_on && !good; endproperty
   property p_enh;   (!full_enh_pin) [*4] |-> !good; endproperty
   property p_gate;  good |-> gate_on; endproperty
   property p_start; $rose(gate_on) |-> off_cnt >= START_CYC; endproperty
   property p_en;    en_cnt == OFF_FILT_CYC + 4 |-> !gate_on && !good; endproperty
   property p_uv;    uv_cnt == OFF_FILT_CYC + 4 |-> !gate_on && !good; endproperty
   property p_od;    power_ok_out == 1'b0; endproperty

   a_hot:   assert property (p_hot) else $error("switch still on while hot");
   a_trip:  assert property (p_trip) else $error("no breaker trip");
   a_enh:   assert property (p_enh) else $error("good without enhancement");
   a_gate:  assert property (p_gate) else $error("good while gate off");
   a_start: assert property (p_start) else $error("start delay too short");
   a_en:    assert property (p_en) else $error("enable low ignored");
   a_uv:    assert property (p_uv) else $error("undervoltage ignored");
   a_od:    assert property (p_od) else $error("open drain drives high");

   c_start: cover property ($rose(gate_on));
   c_hot:   cover property ($fell(gate_on) && temp_hot_pin);
   c_good:  cover property ($rose(good));
endmodule

bind hss_sequencer hss_sequencer_chk #(
   .POLICY(POLICY), .GOOD_ACTIVE_LO(GOOD_ACTIVE_LO), .OFF_FILT_CYC(OFF_FILT_CYC), .START_CYC(START_CYC)
) i_hss_sequencer_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .enable_pin(enable_pin), .undervolt_pin(undervolt_pin),
   .temp_hot_pin(temp_hot_pin), .full_enh_pin(full_enh_pin), .drop_over_pin(drop_over_pin),
   .gate_on(gate_on), .power_ok_out(power_ok_out), .power_ok_oe_b(power_ok_oe_b)
);
`default_nettype wire

// file: bench/hss_far_model.sv
// Behavioural pass switch and pulled-up power-good pin.
`timescale 1ns/10ps
`default_nettype none
module hss_far_model (
   input  wire logic       clk_sys,
   input  wire logic       gate_on,
   input  wire logic       power_ok_out,
   input  wire logic       power_ok_oe_b,
   input  wire logic [7:0] enh_lag,
   output logic            full_enh_pin,
   output logic            power_ok_in
);
   int lag_cnt = 0;
   initial full_enh_pin = 1'b0;

   // Enhancement lags the gate by a set number of cycles; losing gate drive drops it at once.
   always @(posedge clk_sys) begin
      lag_cnt <= gate_on ? lag_cnt + 1 : 0;
      full_enh_pin <= gate_on && (lag_cnt >= enh_lag);
   end

   // A released open-drain pin reads high through its pull-up.
   assign power_ok_in = power_ok_oe_b ? 1'b1 : power_ok_out;
endmodule
`default_nettype wire

// file: bench/tb_hss_sequencer.sv
// Self-checking testbench of the hot-swap sequencer: latched, retry and breakerless builds side by side.
`timescale 1ns/10ps
`default_nettype none
module tb_hss_sequencer;
   import hss_pkg::*;
   localparam int OFC = 20;
   localparam int STC = 50;
   localparam bit GLO = 1'b1;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        enable_pin = 1'b1;
   logic        undervolt_pin = 1'b0;
   logic        temp_hot_pin = 1'b0;
   logic        temp_cool_pin = 1'b1;
   logic        drop_over_pin = 1'b0;
   logic        full_enh_pin;
   logic        gate_on;
   logic        power_ok_in;
   logic        power_ok_out;
   logic        power_ok_oe_b;
   logic        gate_n, enh_n, pin_n, out_n, oe_n;
   logic        gate_r, enh_r, pin_r, out_r, oe_r;
   logic [7:0]  enh_lag = 8'h03;
   logic [31:0] rd;
   logic [4:0]  lowp;
   int          n_fail = 0;
   int          checks = 0;
   int          k;

   always #12.5 clk_sys = ~clk_sys;

   hss_sequencer #(.POLICY(HSS_POL_LATCHED), .GOOD_ACTIVE_LO(GLO), .OFF_FILT_CYC(OFC), .START_CYC(STC))
   i_hss_sequencer (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_pin(enable_pin),
      .undervolt_pin(undervolt_pin), .temp_hot_pin(temp_hot_pin), .temp_cool_pin(temp_cool_pin),
      .full_enh_pin(full_enh_pin), .drop_over_pin(drop_over_pin), .gate_on(gate_on),
      .power_ok_in(power_ok_in), .power_ok_out(power_ok_out), .power_ok_oe_b(power_ok_oe_b));

   hss_far_model i_hss_far_model (
      .clk_sys(clk_sys), .gate_on(gate_on), .power_ok_out(power_ok_out),
      .power_ok_oe_b(power_ok_oe_b), .enh_lag(enh_lag), .full_enh_pin(full_enh_pin),
      .power_ok_in(power_ok_in));

   // Breakerless active-high build; it sees the same pins but has no register traffic.
   hss_sequencer #(.POLICY(HSS_POL_NONE), .GOOD_ACTIVE_LO(1'b0), .OFF_FILT_CYC(OFC), .START_CYC(STC))
   i_hss_sequencer_none (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(4'h0), .avs_read(1'b0), .avs_write(1'b0),
      .avs_writedata(32'h0), .avs_byteenable(4'h0), .avs_readdata(), .avs_waitrequest(),
      .enable_pin(enable_pin), .undervolt_pin(undervolt_pin), .temp_hot_pin(temp_hot_pin),
      .temp_cool_pin(temp_cool_pin), .full_enh_pin(enh_n), .drop_over_pin(drop_over_pin), .gate_on(gate_n),
      .power_ok_in(pin_n), .power_ok_out(out_n), .power_ok_oe_b(oe_n));

   hss_far_model i_hss_far_model_none (
      .clk_sys(clk_sys), .gate_on(gate_n), .power_ok_out(out_n), .power_ok_oe_b(oe_n), .enh_lag(enh_lag),
      .full_enh_pin(enh_n), .power_ok_in(pin_n));

   // Automatic retry build; a trip must restart it after the start delay with no enable toggle.
   hss_sequencer #(.POLICY(HSS_POL_RETRY), .GOOD_ACTIVE_LO(1'b1), .OFF_FILT_CYC(OFC), .START_CYC(STC))
   i_hss_sequencer_retry (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(4'h0), .avs_read(1'b0), .avs_write(1'b0),
      .avs_writedata(32'h0), .avs_byteenable(4'h0), .avs_readdata(), .avs_waitrequest(),
      .enable_pin(enable_pin), .undervolt_pin(undervolt_pin), .temp_hot_pin(temp_hot_pin),
      .temp_cool_pin(temp_cool_pin), .full_enh_pin(enh_r), .drop_over_pin(drop_over_pin), .gate_on(gate_r),
      .power_ok_in(pin_r), .power_ok_out(out_r), .power_ok_oe_b(oe_r));

   hss_far_model i_hss_far_model_retry (
      .clk_sys(clk_sys), .gate_on(gate_r), .power_ok_out(out_r), .power_ok_oe_b(oe_r), .enh_lag(enh_lag),
      .full_enh_pin(enh_r), .power_ok_in(pin_r));

   // ------
   // Tasks
   // ------
   // Pin level expected for a given power-good state, the pin being pulled up.
   function automatic logic pin_exp(input logic good);
      return GLO ? !good : good;
   endfunction

   task final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon access; the request stands until the rising edge that samples waitrequest low.
   // Only the watchdog ends a wait that never finishes.
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk(k, 2);
   endtask

   task pins(input logic [4:0] p);
      @(posedge clk_sys);
      {enable_pin, undervolt_pin, temp_hot_pin, temp_cool_pin, drop_over_pin} <= p;
   endtask

   task wait_gate(input logic v, input int lo, input int hi);
      k = 0;
      while (gate_on !== v && k <= hi) begin
         @(posedge clk_sys);
         k++;
      end
      chk(k >= lo && k <= hi, 1);
   endtask

   task hold_gate(input logic v, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge clk_sys);
         if (gate_on !== v) bad++;
      end
      chk(bad, 0);
   endtask

   // Start after the full delay, then power-good once the switch is enhanced.
   task up;
      wait_gate(1'b1, STC, STC + 10);
      repeat (14) @(posedge clk_sys);
      chk(power_ok_in, pin_exp(1'b1));
      enh_lag <= 8'(1 + $urandom % 8);
   endtask

   // ------
   // Main sequence
   // ------
   initial begin
      void'($urandom(32'hFDBDC946));
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      up();
      bus(1'b0, CTRL_OFS, 32'h0);
      chk(rd[CTRL_SWEN_BIT], CTRL_SWEN_RST);
      bus(1'b0, STAT_OFS, 32'h0);
      chk(rd[8:0], {pin_exp(1'b1), 4'h0, 1'b1, 1'b1, HSS_ST_ON});
      bus(1'b1, 4'hC, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h0);
      wait_gate(1'b0, 0, 4);
      bus(1'b1, CTRL_OFS, 32'h1);
      up();
      $display("test 1 done");
      // Enable low, then undervoltage: short episodes ignored, long ones switch off.
      for (int i = 0; i < 2; i++) begin
         lowp = i ? 5'b11010 : 5'b00010;
         pins(lowp);
         repeat (1 + $urandom % (OFC - 4)) @(posedge clk_sys);
         pins(5'b10010);
         hold_gate(1'b1, OFC + 8);
         pins(lowp);
         wait_gate(1'b0, OFC, OFC + 8);
         chk(power_ok_in, pin_exp(1'b0));
         pins(5'b10010);
         up();
         $display("test %0d done", i + 2);
      end
      // Breaker trip latches off until enable is held low and released.
      pins(5'b10011);
      wait_gate(1'b0, 0, 4);
      chk(power_ok_in, pin_exp(1'b0));
      chk(gate_n, 1'b1);
      pins(5'b10010);
      hold_gate(1'b0, STC + 10);
      chk(gate_r, 1'b1);
      bus(1'b0, STAT_OFS, 32'h0);
      chk(rd[STAT_LATCH_BIT], 1'b1);
      pins(5'b00010);
      repeat (OFC + 4) @(posedge clk_sys);
      pins(5'b10010);
      up();
      $display("test 4 done");
      // A power cycle also clears the latch.
      pins(5'b10011);
      wait_gate(1'b0, 0, 4);
      pins(5'b10010);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      up();
      $display("test 5 done");
      // Thermal shutdown restarts only once the die is below the lower level.
      pins(5'b10100);
      wait_gate(1'b0, 0, 4);
      chk(power_ok_in, pin_exp(1'b0));
      chk(pin_n, 1'b0);
      pins(5'b10000);
      hold_gate(1'b0, STC + 10);
      pins(5'b10010);
      up();
      $display("test 6 done");
      // Drop is ignored until the switch is fully enhanced, then trips.
      pins(5'b00010);
      wait_gate(1'b0, OFC, OFC + 8);
      enh_lag <= 8'd40;
      pins(5'b10011);
      wait_gate(1'b1, STC, STC + 10);
      hold_gate(1'b1, 30);
      wait_gate(1'b0, 0, 20);
      repeat (10) @(posedge clk_sys);
      chk({gate_n, pin_n}, 2'b11);
      $display("test 7 done");
      final_report();
   end

   // Watchdog well beyond the thousand or so cycles the tests take.
   initial begin
      #(25 * 20000);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
